// ==== rtl/lvpm_pkg.sv ====
`default_nettype none
package lvpm_pkg;
	localparam logic [11:0] ADDR_DETECT = 12'h000;
	localparam logic [11:0] ADDR_WARN = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00c;
	localparam logic [11:0] ADDR_ID = 12'h010;
	localparam logic [31:0] ID_VALUE = 32'h0000_0a5c; // Arbitrary value
	// Register 1 fields
	localparam int B_DFLAG = 7;
	localparam int B_DACK = 6;
	localparam int B_DIRQ = 5;
	localparam int B_DRST = 4;
	localparam int B_DSTOP = 3;
	localparam int B_DEN = 2;
	localparam int B_REFBUF = 0;
	// Register 2 fields
	localparam int B_WFLAG = 7;
	localparam int B_WACK = 6;
	localparam int B_DTRIP = 5;
	localparam int B_WTRIP = 4;
	localparam int B_RFLAG = 3;
	localparam int B_RACK = 2;
	localparam int B_DEPTH = 0;
	// Interrupt status bits
	localparam int S_DETECT = 0;
	localparam int S_WARN = 1;
	localparam int S_RECOV = 2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic detect_en;
		logic irq_en;
		logic reset_en;
		logic stop_en;
		logic ref_buf;
	} lvpm_ctrl_s;
endpackage : lvpm_pkg
`default_nettype wire

// ==== rtl/lvpm_regs.sv ====
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
module lvpm_regs (
	// Clock and resets
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_por,
	// AXI4-Lite write
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Supply monitor
	input wire logic i_detect_low,
	input wire logic i_warn_low,
	input wire logic i_in_stop,
	input wire logic i_deep_stop_exit,
	output logic o_detect_trip_select,
	output logic o_warn_trip_select,
	output logic o_detect_active,
	// System
	output logic o_ref_buffer_en,
	output logic o_stop_depth_select,
	output logic o_detect_irq,
	output logic o_chip_reset_req,
	output logic o_irq
);
	////////////////////////////////////////////////////////////////////////
	lvpm_pkg::lvpm_ctrl_s ctrl;
	logic detect_flag;
	logic warn_flag;
	logic detect_trip;
	logic warn_trip;
	logic recov_flag;
	logic depth;
	logic depth_done;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [11:0] aw_addr;
	logic aw_held;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_held;
	logic wr_go;
	logic [11:0] wa;
	logic [31:0] wd;
	logic wb0;
	logic rd_go;
	logic [31:0] next_rdata;
	logic detect_live;
	logic [2:0] ev;
	logic wr_detect;
	logic wr_warn;
	logic rd_status;

	////////////////////////////////////////////////////////////////////////
	// Response code for an address, shared by both channels
	function automatic logic [1:0] addr_resp(input logic [11:0] addr);
		addr_resp = (addr[11:2] <= lvpm_pkg::ADDR_ID[11:2]) ?
			lvpm_pkg::RESP_OKAY : lvpm_pkg::RESP_SLVERR;
	endfunction : addr_resp

	////////////////////////////////////////////////////////////////////////
	// Write channel capture
	assign o_awready = !aw_held && !o_bvalid;
	assign o_wready = !w_held && !o_bvalid;
	assign wa = aw_held ? aw_addr : i_awaddr;
	assign wd = w_held ? w_data : i_wdata;
	assign wb0 = w_held ? w_strb[0] : i_wstrb[0];
	assign wr_go = (aw_held || i_awvalid) && (w_held || i_wvalid) &&
		!o_bvalid;
	assign wr_detect = wr_go && wb0 && wa == lvpm_pkg::ADDR_DETECT;
	assign wr_warn = wr_go && wb0 && wa == lvpm_pkg::ADDR_WARN;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp <= lvpm_pkg::RESP_OKAY;
		end else begin
			if (wr_go) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= addr_resp(wa);
			end else begin
				if (i_awvalid && o_awready) begin
					aw_held <= 1'b1;
					aw_addr <= i_awaddr;
				end
				if (i_wvalid && o_wready) begin
					w_held <= 1'b1;
					w_data <= i_wdata;
					w_strb <= i_wstrb;
				end
				if (o_bvalid && i_bready)
					o_bvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Detect register
	assign detect_live = ctrl.detect_en &&
		(!i_in_stop || ctrl.stop_en);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ctrl <= '0;
		end else if (wr_detect) begin
			ctrl.irq_en <= wd[lvpm_pkg::B_DIRQ];
			ctrl.reset_en <= wd[lvpm_pkg::B_DRST];
			ctrl.stop_en <= wd[lvpm_pkg::B_DSTOP];
			ctrl.detect_en <= wd[lvpm_pkg::B_DEN];
			ctrl.ref_buf <= wd[lvpm_pkg::B_REFBUF];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			detect_flag <= 1'b0;
		else if (detect_live && i_detect_low)
			detect_flag <= 1'b1;
		else if (wr_detect && wd[lvpm_pkg::B_DACK])
			detect_flag <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Warning register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			warn_flag <= 1'b0;
		else if (i_warn_low)
			warn_flag <= 1'b1;
		else if (wr_warn && wd[lvpm_pkg::B_WACK])
			warn_flag <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst && i_por) begin
			detect_trip <= 1'b0;
			warn_trip <= 1'b0;
		end else if (!i_sys_rst && wr_warn) begin
			detect_trip <= wd[lvpm_pkg::B_DTRIP];
			warn_trip <= wd[lvpm_pkg::B_WTRIP];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			recov_flag <= 1'b0;
		else if (i_deep_stop_exit)
			recov_flag <= 1'b1;
		else if (wr_warn && wd[lvpm_pkg::B_RACK])
			recov_flag <= 1'b0;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			depth <= 1'b0;
			depth_done <= 1'b0;
		end else if (wr_warn && !depth_done) begin
			depth <= wd[lvpm_pkg::B_DEPTH];
			depth_done <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt status, mask
	assign rd_status = rd_go && i_araddr == lvpm_pkg::ADDR_IRQ_STATUS;
	assign ev[lvpm_pkg::S_DETECT] = detect_live && i_detect_low &&
		!detect_flag;
	assign ev[lvpm_pkg::S_WARN] = i_warn_low && !warn_flag;
	assign ev[lvpm_pkg::S_RECOV] = i_deep_stop_exit && !recov_flag;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			irq_status <= 3'h0;
		else
			irq_status <= ev | (rd_status ? 3'h0 : irq_status);
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			irq_mask <= 3'h0;
		else if (wr_go && wb0 && wa == lvpm_pkg::ADDR_IRQ_MASK)
			irq_mask <= wd[2:0];
	end

	assign o_irq = |(irq_status & irq_mask);

	////////////////////////////////////////////////////////////////////////
	// Read channel
	assign o_arready = !o_rvalid;
	assign rd_go = i_arvalid && o_arready;

	always_comb begin
		next_rdata = 32'h0000_0000;
		unique case (i_araddr)
			lvpm_pkg::ADDR_DETECT: begin
				next_rdata[lvpm_pkg::B_DFLAG] = detect_flag;
				next_rdata[lvpm_pkg::B_DIRQ] = ctrl.irq_en;
				next_rdata[lvpm_pkg::B_DRST] = ctrl.reset_en;
				next_rdata[lvpm_pkg::B_DSTOP] = ctrl.stop_en;
				next_rdata[lvpm_pkg::B_DEN] = ctrl.detect_en;
				next_rdata[lvpm_pkg::B_REFBUF] = ctrl.ref_buf;
			end
			lvpm_pkg::ADDR_WARN: begin
				next_rdata[lvpm_pkg::B_WFLAG] = warn_flag;
				next_rdata[lvpm_pkg::B_DTRIP] = detect_trip;
				next_rdata[lvpm_pkg::B_WTRIP] = warn_trip;
				next_rdata[lvpm_pkg::B_RFLAG] = recov_flag;
				next_rdata[lvpm_pkg::B_DEPTH] = depth;
			end
			lvpm_pkg::ADDR_IRQ_STATUS: next_rdata[2:0] = irq_status;
			lvpm_pkg::ADDR_IRQ_MASK: next_rdata[2:0] = irq_mask;
			lvpm_pkg::ADDR_ID: next_rdata = lvpm_pkg::ID_VALUE;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= lvpm_pkg::RESP_OKAY;
		end else if (rd_go) begin
			o_rvalid <= 1'b1;
			o_rdata <= next_rdata;
			o_rresp <= addr_resp(i_araddr);
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_detect_irq <= 1'b0;
			o_chip_reset_req <= 1'b0;
		end else begin
			o_detect_irq <= ctrl.detect_en && ctrl.irq_en &&
				detect_flag;
			o_chip_reset_req <= ctrl.detect_en && ctrl.reset_en &&
				detect_flag;
		end
	end

	assign o_ref_buffer_en = ctrl.ref_buf;
	assign o_detect_trip_select = detect_trip;
	assign o_warn_trip_select = warn_trip;
	assign o_stop_depth_select = depth;
	assign o_detect_active = detect_live;
endmodule : lvpm_regs
`default_nettype wire

// ==== tb/lvpm_regs_monitor.sv ====
`default_nettype none
module lvpm_regs_monitor (
	// Watched ports
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_awvalid,
	input wire logic i_wvalid,
	input wire logic i_arvalid,
	input wire logic i_in_stop,
	input wire logic o_awready,
	input wire logic o_wready,
	input wire logic o_arready,
	input wire logic o_bvalid,
	input wire logic o_rvalid,
	input wire logic o_detect_active,
	input wire logic o_detect_irq,
	input wire logic o_chip_reset_req,
	input wire logic o_irq,
	input wire logic o_detect_trip_select,
	input wire logic o_warn_trip_select,
	input wire logic o_stop_depth_select
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_reset_quiet: assert property ($past(i_sys_rst) |->
		!o_detect_irq && !o_chip_reset_req && !o_irq) else $error("reset out");
	a_trip_by_write: assert property (
		$changed({o_detect_trip_select, o_warn_trip_select}) |-> o_bvalid)
		else $error("trip change");
	a_depth_kept: assert property (o_stop_depth_select |=>
		o_stop_depth_select) else $error("depth change");
	a_detect_gated: assert property ((!o_detect_active && !i_in_stop)[*2]
		|-> !o_detect_irq && !o_chip_reset_req) else $error("not gated");
	a_write_answer: assert property (i_awvalid && o_awready && i_wvalid &&
		o_wready |=> o_bvalid) else $error("no bvalid");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("no rvalid");
	a_write_refused: assert property (o_bvalid |-> !o_awready && !o_wready)
		else $error("write taken");
	a_read_refused: assert property (o_rvalid |-> !o_arready)
		else $error("read taken");
endmodule : lvpm_regs_monitor
`default_nettype wire

// ==== tb/lvpm_regs_test.sv ====
`default_nettype none
module lvpm_regs_test;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic wr;
		logic [11:0] a;
		logic [7:0] d;
		logic [31:0] e;
		logic [1:0] r;
	} lvpm_row_s;
	logic i_clk = 1'h0, i_sys_rst = 1'h1, i_por = 1'h1, i_in_stop = 1'h0;
	logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
	logic i_arvalid = 1'h0, i_rready = 1'h0, i_deep_stop_exit = 1'h0;
	logic [11:0] i_awaddr = 12'h0, i_araddr = 12'h0;
	logic [31:0] i_wdata = 32'h0, o_rdata;
	logic [3:0] i_wstrb = 4'h1;
	logic [1:0] o_bresp, o_rresp, lvl = 2'h3;
	logic i_detect_low, i_warn_low, o_awready, o_wready, o_bvalid, o_irq;
	logic o_arready, o_rvalid, o_detect_trip_select, o_warn_trip_select;
	logic o_detect_active, o_ref_buffer_en, o_stop_depth_select;
	logic o_detect_irq, o_chip_reset_req;
	int fails = 0, samples_checked = 0;
	lvpm_row_s rows[8] = '{
		'{1'h1, 12'h00c, 8'h07, 32'h07, 2'h0},
		'{1'h1, 12'h000, 8'h2d, 32'h2d, 2'h0},
		'{1'h1, 12'h004, 8'h31, 32'h31, 2'h0},
		'{1'h1, 12'h004, 8'h00, 32'h01, 2'h0},
		'{1'h1, 12'h004, 8'h36, 32'h31, 2'h0},
		'{1'h1, 12'h000, 8'h6d, 32'h2d, 2'h0},
		'{1'h0, 12'h010, 8'h00, lvpm_pkg::ID_VALUE, 2'h0},
		'{1'h1, 12'h014, 8'h5a, 32'h0, 2'h2}};
	lvpm_regs dut (.*);
	lvpm_supply_model u_sup (.i_clk(i_clk), .i_level(lvl),
		.i_detect_trip_select(o_detect_trip_select),
		.i_warn_trip_select(o_warn_trip_select),
		.o_detect_low(i_detect_low), .o_warn_low(i_warn_low));
	always #50 i_clk = ~i_clk;
	task automatic chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	task automatic hold(input int k);
		logic s;
		for (int n = 0; n < 64; n++) begin
			@(posedge i_clk);
			s = k == 0 ? o_awready && o_wready : k == 1 ? o_bvalid
				: k == 2 ? o_arready : o_rvalid;
			if (s === 1'h1)
				return;
		end
		chk("handshake", 1, 0);
		give_verdict();
	endtask : hold
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge i_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'h1;
		i_wvalid <= 1'h1;
		i_bready <= 1'h1;
		hold(0);
		i_awvalid <= 1'h0;
		i_wvalid <= 1'h0;
		hold(1);
		i_bready <= 1'h0;
		chk("bresp", r, o_bresp);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge i_clk);
		i_araddr <= a;
		i_arvalid <= 1'h1;
		i_rready <= 1'h1;
		hold(2);
		i_arvalid <= 1'h0;
		hold(3);
		i_rready <= 1'h0;
		chk("rdata", e, o_rdata);
		chk("rresp", r, o_rresp);
	endtask : rd
	task automatic do_reset(input logic p);
		i_sys_rst <= 1'h1;
		i_por <= p;
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		repeat (3) @(posedge i_clk);
	endtask : do_reset
	initial begin
		do_reset(1'h1);
		foreach (rows[i]) begin
			if (rows[i].wr)
				wr(rows[i].a, {24'h0, rows[i].d}, rows[i].r);
			rd(rows[i].a, rows[i].e, rows[i].r);
		end
		chk("ref buffer", 1, o_ref_buffer_en);
		chk("depth", 1, o_stop_depth_select);
		chk("detect trip", 1, o_detect_trip_select);
		chk("warn trip", 1, o_warn_trip_select);
		$display("table done");
		lvl <= 2'h0;
		repeat (5) @(posedge i_clk);
		chk("detect irq", 1, o_detect_irq);
		chk("chip reset", 0, o_chip_reset_req);
		rd(12'h000, 32'had, 2'h0);
		rd(12'h004, 32'hb1, 2'h0);
		wr(12'h004, 32'h70, 2'h0);
		rd(12'h004, 32'hb1, 2'h0);
		lvl <= 2'h3;
		repeat (3) @(posedge i_clk);
		rd(12'h004, 32'hb1, 2'h0);
		wr(12'h004, 32'h70, 2'h0);
		rd(12'h004, 32'h31, 2'h0);
		i_deep_stop_exit <= 1'h1;
		@(posedge i_clk);
		i_deep_stop_exit <= 1'h0;
		rd(12'h004, 32'h39, 2'h0);
		wr(12'h004, 32'h34, 2'h0);
		rd(12'h004, 32'h31, 2'h0);
		chk("irq", 1, o_irq);
		rd(12'h008, 32'h07, 2'h0);
		rd(12'h008, 32'h00, 2'h0);
		chk("irq", 0, o_irq);
		$display("events done");
		i_wstrb <= 4'h0;
		wr(12'h00c, 32'h00, 2'h0);
		i_wstrb <= 4'h1;
		rd(12'h00c, 32'h07, 2'h0);
		i_in_stop <= 1'h1;
		@(posedge i_clk);
		chk("detect active", 1, o_detect_active);
		wr(12'h000, 32'h14, 2'h0);
		chk("detect active", 0, o_detect_active);
		i_in_stop <= 1'h0;
		lvl <= 2'h0;
		repeat (5) @(posedge i_clk);
		chk("chip reset", 1, o_chip_reset_req);
		chk("detect irq", 0, o_detect_irq);
		chk("detect active", 1, o_detect_active);
		wr(12'h000, 32'h10, 2'h0);
		repeat (2) @(posedge i_clk);
		chk("chip reset", 0, o_chip_reset_req);
		chk("detect active", 0, o_detect_active);
		$display("stop done");
		lvl <= 2'h1;
		do_reset(1'h0);
		rd(12'h004, 32'hb0, 2'h0);
		rd(12'h000, 32'h00, 2'h0);
		chk("detect trip", 1, o_detect_trip_select);
		chk("warn trip", 1, o_warn_trip_select);
		chk("depth", 0, o_stop_depth_select);
		do_reset(1'h1);
		rd(12'h004, 32'h80, 2'h0);
		chk("detect trip", 0, o_detect_trip_select);
		$display("resets done");
		give_verdict();
	end
endmodule : lvpm_regs_test
bind lvpm_regs lvpm_regs_monitor u_mon (.*);
`default_nettype wire

// ==== tb/lvpm_supply_model.sv ====
`default_nettype none
module lvpm_supply_model (
	// Supply level and trip selects
	input wire logic i_clk,
	input wire logic [1:0] i_level,
	input wire logic i_detect_trip_select,
	input wire logic i_warn_trip_select,
	// Comparator outputs
	output logic o_detect_low = 1'h0,
	output logic o_warn_low = 1'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge i_clk) begin
		o_detect_low <= i_level < (i_detect_trip_select ? 2'h2 : 2'h1);
		o_warn_low <= i_level < (i_warn_trip_select ? 2'h3 : 2'h2);
	end
endmodule : lvpm_supply_model
`default_nettype wire
